// ===== hdl/blc_map.svh
// Level-2 cache constants: geometry, address fields, windows, reset values.
// Included by the package and every design file; definitions only.
`ifndef BLC_MAP_SVH
`define BLC_MAP_SVH

// ----------------------------------------
// Geometry and widths
// ----------------------------------------
`define BLC_ADDR_W 38
`define BLC_DATA_W 128
`define BLC_BE_W 16
`define BLC_ID_W 4
`define BLC_MAST 4
`define BLC_MID_W 2
`define BLC_TAG_W 21
`define BLC_NBANK 4
`define BLC_NSET 512
`define BLC_NWAY 16
`define BLC_NBEAT 4
`define BLC_CNT_W 16

// ----------------------------------------
// Address fields and windows
// ----------------------------------------
`define BLC_BEAT_LSB 4
`define BLC_BANK_LSB 6
`define BLC_SET_LSB 8
`define BLC_TAG_LSB 17
`define BLC_LIM_LSB 21
`define BLC_LIM_BASE 38'h0_0800_0000
`define BLC_SCR_LSB 25
`define BLC_SCR_BASE 38'h0_0A00_0000

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BLC_WAY_EN_RST 16'h0001

`endif

// ===== hdl/blc_pkg.sv
// Types shared by the level-2 cache top and its bank storage.
// Assumes blc_map.svh is on the include path.
package blc_pkg;
`include "blc_map.svh"

// ----------------------------------------
// Bank sequencer states
// ----------------------------------------
typedef enum logic [1:0] {ST_IDLE, ST_WB, ST_FILL, ST_REPLAY} blc_state_t;

// ----------------------------------------
// Carriers
// ----------------------------------------
// Inner port request, one 128-bit beat
typedef struct packed {
	logic valid;
	logic write;
	logic [`BLC_MID_W-1:0] mid;
	logic [`BLC_ID_W-1:0] id;
	logic [`BLC_ADDR_W-1:0] addr;
	logic [`BLC_DATA_W-1:0] wdata;
	logic [`BLC_BE_W-1:0] be;
} blc_req_t;

typedef struct packed {
	logic valid;
	logic err;
	logic [`BLC_ID_W-1:0] id;
	logic [`BLC_DATA_W-1:0] rdata;
} blc_rsp_t;

// Outer port beat to memory
typedef struct packed {
	logic valid;
	logic write;
	logic [`BLC_ADDR_W-1:0] addr;
	logic [`BLC_DATA_W-1:0] wdata;
} blc_out_t;

// Invalidation for the first-level caches of listed masters
typedef struct packed {
	logic valid;
	logic [`BLC_ADDR_W-1:0] addr;
	logic [`BLC_MAST-1:0] targets;
} blc_probe_t;

// Per-line tag state with directory of sharers
typedef struct packed {
	logic valid;
	logic dirty;
	logic scratch;
	logic [`BLC_MAST-1:0] sharers;
	logic [`BLC_TAG_W-1:0] tag;
} blc_meta_t;

endpackage

// ===== hdl/blc_store.sv
// One cache bank's storage: tags with directory, data beats, byte check bits.
// Assumes one data access and one tag write per cycle, chosen by the bank sequencer.
`timescale 1ns/10ps
`include "blc_map.svh"

module blc_store #(
	parameter int SETS = `BLC_NSET,
	parameter int WAYS = `BLC_NWAY
)(
	input wire logic clock,
	input wire logic rst,
	input wire logic [$clog2(SETS)-1:0] m_set,
	output blc_pkg::blc_meta_t [WAYS-1:0] metas,
	input wire logic m_we,
	input wire logic [$clog2(WAYS)-1:0] m_way,
	input wire blc_pkg::blc_meta_t m_meta,
	input wire logic [$clog2(SETS)-1:0] d_set,
	input wire logic [$clog2(WAYS)-1:0] d_way,
	input wire logic [1:0] d_beat,
	input wire logic d_we,
	input wire logic [`BLC_BE_W-1:0] d_be,
	input wire logic [`BLC_DATA_W-1:0] d_wdata,
	output logic [`BLC_DATA_W-1:0] d_rdata,
	output logic d_err,
	input wire logic inject
);

localparam int SW = $clog2(SETS);
localparam int WW = $clog2(WAYS);
localparam int NB = `BLC_NBEAT;

// ----------------------------------------
// Arrays
// ----------------------------------------
// Sets x ways lines of four beats each per bank
blc_pkg::blc_meta_t meta_mem [SETS*WAYS];
logic [SETS*WAYS-1:0] vld_reg;
logic [`BLC_DATA_W-1:0] data_mem [SETS*WAYS*NB];
logic [`BLC_BE_W-1:0] chk_mem [SETS*WAYS*NB];
logic [SW+WW+1:0] d_idx;
logic [`BLC_BE_W-1:0] wchk;

// Byte parity, so partial writes stay checked
function automatic logic [`BLC_BE_W-1:0] chk_of(input logic [`BLC_DATA_W-1:0] d);
	logic [`BLC_BE_W-1:0] c;
	c = '0;
	for (int i = 0; i < `BLC_BE_W; i++)
		c[i] = ^d[8*i +: 8];
	return c;
endfunction

// ----------------------------------------
// Read side
// ----------------------------------------
// Whole set read at once for the parallel compare
always_comb
begin
	for (int w = 0; w < WAYS; w++)
	begin
		metas[w] = meta_mem[{m_set, WW'(w)}];
		metas[w].valid = vld_reg[{m_set, WW'(w)}];
	end
end

assign d_idx = {d_set, d_way, d_beat};
assign d_rdata = data_mem[d_idx];
assign d_err = chk_of(d_rdata) != chk_mem[d_idx];
assign wchk = chk_of(d_wdata);

// ----------------------------------------
// Write side
// ----------------------------------------
// Only valid bits need reset; stale tags are harmless behind them
always_ff @(posedge clock or posedge rst)
begin
	if (rst)
		vld_reg <= '0;
	else if (m_we)
		vld_reg[{m_set, m_way}] <= m_meta.valid;
end

// Tag store
always_ff @(posedge clock)
begin
	if (m_we)
		meta_mem[{m_set, m_way}] <= m_meta;
end

// Byte-masked data write; injection flips the check bit of byte 0
always_ff @(posedge clock)
begin
	for (int i = 0; i < `BLC_BE_W; i++)
	begin
		if (d_we && d_be[i])
		begin
			data_mem[d_idx][8*i +: 8] <= d_wdata[8*i +: 8];
			chk_mem[d_idx][i] <= wchk[i] ^ (inject && i == 0);
		end
	end
end

endmodule

// ===== hdl/blc_l2.sv
// Banked level-2 cache: local-memory window, scratch region, directory.
// Assumes each request arrives on its bank's port and memory answers outer
// reads in order, one beat per out_rvalid.
// Contract
// - Storage is four banks of 512 sets by 16 ways, each way line holding 64 bytes.
// - Each bank has its own 128-bit inner port so different banks work in parallel.
// - One shared 128-bit outer port carries all refills except scratch ones and all writebacks to memory.
// - Ways disabled for caching are read and written directly through the local-memory window.
// - Local-memory accesses always complete with hit latency and never miss.
// - A local-memory access beats a refill or writeback access to the same bank, but waits out a replay.
// - After reset only way 0 caches and every other way is local memory.
// - Ways are enabled by writes and stay enabled until reset; disables are ignored.
// - The highest way sits at the lowest window addresses and way 1 at the highest.
// - An enabled way leaves the local-memory window, shrinking it.
// - Scratch region writes allocate only into enabled, unmasked ways.
// - Evicted scratch lines are dropped with no writeback.
// - The scratch region is cacheable and tracked like other cached lines.
// - A directory tracks which masters hold each line and keeps them coherent.
// - Way masking, way locking and checked storage with error count and injection exist.
`timescale 1ns/10ps
`include "blc_map.svh"

module blc_l2 #(
	parameter int NBANK = `BLC_NBANK,
	parameter int NSET = `BLC_NSET,
	parameter int NWAY = `BLC_NWAY
)(
	input wire logic clock,
	input wire logic rst,
	input wire blc_pkg::blc_req_t [NBANK-1:0] in_req,
	output logic [NBANK-1:0] in_ready,
	output logic [NBANK-1:0] in_lim_ready,
	output blc_pkg::blc_rsp_t [NBANK-1:0] in_rsp,
	output blc_pkg::blc_probe_t [NBANK-1:0] probe,
	output blc_pkg::blc_out_t out_req,
	input wire logic out_ready,
	input wire logic out_rvalid,
	input wire logic [`BLC_DATA_W-1:0] out_rdata,
	input wire logic way_enable_wr,
	input wire logic [NWAY-1:0] way_enable_data,
	input wire logic [NWAY-1:0] way_mask,
	input wire logic [NWAY-1:0] way_lock,
	input wire logic ecc_inject,
	output logic [NWAY-1:0] way_enabled,
	output logic [NBANK-1:0] ecc_event,
	output logic [NBANK-1:0][`BLC_CNT_W-1:0] ecc_count
);

localparam int WW = $clog2(NWAY);
localparam int SW = $clog2(NSET);
localparam int BW = $clog2(NBANK);
localparam int AW = `BLC_ADDR_W;
localparam int TW = `BLC_TAG_W;
localparam int MAST = `BLC_MAST;
localparam logic [AW-1:0] LIM_BASE = `BLC_LIM_BASE;
localparam logic [AW-1:0] SCR_BASE = `BLC_SCR_BASE;
localparam logic [WW-1:0] WAY_TOP = WW'(NWAY - 1);
localparam logic [1:0] BEAT_LAST = 2'(`BLC_NBEAT - 1);

// ----------------------------------------
// Helpers
// ----------------------------------------
function automatic logic [WW-1:0] first_one(input logic [NWAY-1:0] v);
	logic [WW-1:0] idx;
	idx = '0;
	for (int i = NWAY - 1; i >= 0; i--)
		if (v[i])
			idx = WW'(i);
	return idx;
endfunction

function automatic logic in_region(input logic [AW-1:0] a, input logic [AW-1:0] base,
	input int lsb);
	return (a >> lsb) == (base >> lsb);
endfunction

// ----------------------------------------
// Way enables
// ----------------------------------------
logic [NWAY-1:0] en_reg;

// Set-only: a written zero never clears an enabled way
always_ff @(posedge clock or posedge rst)
begin
	if (rst)
		en_reg <= NWAY'(`BLC_WAY_EN_RST);
	else if (way_enable_wr)
		en_reg <= en_reg | way_enable_data;
end

assign way_enabled = en_reg;

// ----------------------------------------
// Outer port arbiter
// ----------------------------------------
blc_pkg::blc_out_t out_reg;
blc_pkg::blc_out_t eng [NBANK];
logic [NBANK-1:0] eng_busy, ld, dn;
logic [BW-1:0] owner_reg, pick;
logic owned_reg, rd_wait_reg, wr_done, rd_done;

// Lowest busy bank wins and keeps the port for its writeback and refill
always_comb
begin
	pick = '0;
	for (int i = NBANK - 1; i >= 0; i--)
		if (eng_busy[i])
			pick = BW'(i);
end

assign wr_done = out_reg.valid && out_ready && out_reg.write;
assign rd_done = rd_wait_reg && out_rvalid;

// Ownership, one beat in flight at a time
always_ff @(posedge clock or posedge rst)
begin
	if (rst)
	begin
		owned_reg <= 1'b0;
		owner_reg <= '0;
		rd_wait_reg <= 1'b0;
		out_reg <= '0;
	end
	else
	begin
		if (!owned_reg && |eng_busy)
		begin
			owned_reg <= 1'b1;
			owner_reg <= pick;
		end
		else if (owned_reg && !eng_busy[owner_reg] && !out_reg.valid && !rd_wait_reg)
			owned_reg <= 1'b0;
		if (|ld)
			out_reg <= eng[owner_reg];
		else if (out_ready)
			out_reg.valid <= 1'b0;
		if (out_reg.valid && out_ready && !out_reg.write)
			rd_wait_reg <= 1'b1;
		else if (out_rvalid)
			rd_wait_reg <= 1'b0;
	end
end

assign out_req = out_reg;

// ----------------------------------------
// Banks
// ----------------------------------------
for (genvar b = 0; b < NBANK; b++)
begin : g_bank
	blc_pkg::blc_state_t state_reg, state_next;
	blc_pkg::blc_req_t pend_reg, act;
	blc_pkg::blc_meta_t vic_meta_reg, vmeta, upd, fill_meta, m_meta;
	blc_pkg::blc_meta_t [NWAY-1:0] metas;
	blc_pkg::blc_rsp_t rsp_reg, rsp_next;
	blc_pkg::blc_probe_t probe_reg, probe_next;
	logic [WW-1:0] vic_way_reg, rr_reg, hit_way, vic_way, lim_way, slot, d_way, m_way;
	logic [SW-1:0] act_set, pend_set, d_set, m_set;
	logic [NWAY-1:0] hit_vec, vld_vec, allowed, inv;
	logic [MAST-1:0] me, others;
	logic [1:0] beat_reg, d_beat;
	logic [`BLC_DATA_W-1:0] fbuf_reg, d_rdata, d_wdata, fill_data;
	logic [`BLC_BE_W-1:0] d_be;
	logic [`BLC_CNT_W-1:0] cnt_reg;
	logic issued_reg, have_reg, ready_reg, lim_ready_reg, ecc_reg;
	logic bank_ok, is_lim, lim_ok, lim_go, look_go, hit, hit_ok, hit_wr, miss_take, wb_need;
	logic in_eng, pend_scr, fill_wr, d_we, m_we, d_err, ecc_hit;

	// Replay reuses the lookup path with the parked request
	assign act = (state_reg == blc_pkg::ST_REPLAY) ? pend_reg : in_req[b];
	assign act_set = act.addr[`BLC_SET_LSB +: SW];
	assign pend_set = pend_reg.addr[`BLC_SET_LSB +: SW];
	assign bank_ok = act.addr[`BLC_BANK_LSB +: BW] == BW'(b);
	assign me = MAST'(1) << act.mid;
	assign in_eng = state_reg == blc_pkg::ST_WB || state_reg == blc_pkg::ST_FILL;
	assign pend_scr = in_region(pend_reg.addr, SCR_BASE, `BLC_SCR_LSB);

	// Local-memory window: slot 0 is the top way, the slot of way 0 is never mapped
	assign is_lim = in_region(act.addr, LIM_BASE, `BLC_LIM_LSB);
	assign slot = act.addr[`BLC_TAG_LSB +: WW];
	assign lim_way = WAY_TOP - slot;
	assign lim_ok = bank_ok && slot != WAY_TOP && !en_reg[lim_way];
	assign lim_go = in_req[b].valid && lim_ready_reg && is_lim &&
		state_reg != blc_pkg::ST_REPLAY;
	assign look_go = (state_reg == blc_pkg::ST_IDLE && ready_reg && in_req[b].valid && !is_lim)
		|| state_reg == blc_pkg::ST_REPLAY;

	// Tag compare over enabled ways; scratch lines too
	always_comb
	begin
		hit_vec = '0;
		vld_vec = '0;
		for (int w = 0; w < NWAY; w++)
		begin
			vld_vec[w] = metas[w].valid;
			hit_vec[w] = en_reg[w] && metas[w].valid && metas[w].tag == act.addr[AW-1 -: TW];
		end
	end

	assign hit = |hit_vec;
	assign hit_way = first_one(hit_vec);
	assign hit_ok = look_go && bank_ok && hit;
	assign hit_wr = hit_ok && act.write;
	assign others = metas[hit_way].sharers & ~me;
	// Masked and locked ways are never chosen for a new line
	assign allowed = en_reg & ~way_mask & ~way_lock;
	assign inv = allowed & ~vld_vec;
	assign vic_way = |inv ? first_one(inv) : (allowed[rr_reg] ? rr_reg : first_one(allowed));
	assign vmeta = metas[vic_way];
	assign miss_take = state_reg == blc_pkg::ST_IDLE && look_go && bank_ok && !hit && |allowed;
	assign wb_need = vmeta.valid && vmeta.dirty && !vmeta.scratch;
	assign fill_data = pend_scr ? '0 : fbuf_reg;
	assign fill_wr = state_reg == blc_pkg::ST_FILL && (have_reg || pend_scr) && !lim_go;

	// Storage port: local memory first, then the refill engine, then lookup
	assign d_set = (in_eng && !lim_go) ? pend_set : act_set;
	assign d_way = lim_go ? lim_way : (in_eng ? vic_way_reg : hit_way);
	assign d_beat = (in_eng && !lim_go) ? beat_reg : act.addr[`BLC_BEAT_LSB +: 2];
	assign d_we = lim_go ? (act.write && lim_ok) : (fill_wr || hit_wr);
	assign d_be = fill_wr ? '1 : act.be;
	assign d_wdata = fill_wr ? fill_data : act.wdata;
	assign m_set = in_eng ? pend_set : act_set;
	assign m_we = (fill_wr && beat_reg == BEAT_LAST) || hit_ok;
	assign m_way = in_eng ? vic_way_reg : hit_way;
	assign m_meta = in_eng ? fill_meta : upd;

	blc_store #(
		.SETS(NSET),
		.WAYS(NWAY)
	) u_store (
		.clock(clock),
		.rst(rst),
		.m_set(m_set),
		.metas(metas),
		.m_we(m_we),
		.m_way(m_way),
		.m_meta(m_meta),
		.d_set(d_set),
		.d_way(d_way),
		.d_beat(d_beat),
		.d_we(d_we),
		.d_be(d_be),
		.d_wdata(d_wdata),
		.d_rdata(d_rdata),
		.d_err(d_err),
		.inject(ecc_inject)
	);

	// Directory update on hit and fresh line state on refill
	always_comb
	begin
		upd = metas[hit_way];
		if (act.write)
		begin
			upd.dirty = 1'b1;
			upd.sharers = me;
		end
		else
			upd.sharers = upd.sharers | me;
		fill_meta = '0;
		fill_meta.valid = 1'b1;
		fill_meta.scratch = pend_scr;
		fill_meta.tag = pend_reg.addr[AW-1 -: TW];
	end

	// Invalidate other holders on a write, and all holders of an evicted line
	always_comb
	begin
		probe_next = '0;
		if (hit_wr && |others)
		begin
			probe_next.valid = 1'b1;
			probe_next.addr = {act.addr[AW-1:`BLC_BANK_LSB], 6'h00};
			probe_next.targets = others;
		end
		else if (miss_take && vmeta.valid && |vmeta.sharers)
		begin
			probe_next.valid = 1'b1;
			probe_next.addr = {vmeta.tag, act_set, BW'(b), 6'h00};
			probe_next.targets = vmeta.sharers;
		end
	end

	// Hits, errors and local memory answer one cycle after the access
	assign rsp_next.valid = lim_go || (look_go && (hit || !bank_ok || !(|allowed)));
	assign rsp_next.err = lim_go ? (!lim_ok || (!act.write && d_err)) :
		(!hit_ok || (!act.write && d_err));
	assign rsp_next.id = act.id;
	assign rsp_next.rdata = d_rdata;
	assign ecc_hit = rsp_next.valid && !act.write && d_err && (lim_go ? lim_ok : hit_ok);

	// Sequencer
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			blc_pkg::ST_IDLE:
				if (miss_take)
					state_next = wb_need ? blc_pkg::ST_WB : blc_pkg::ST_FILL;
			blc_pkg::ST_WB:
				if (dn[b] && beat_reg == BEAT_LAST)
					state_next = blc_pkg::ST_FILL;
			blc_pkg::ST_FILL:
				if (fill_wr && beat_reg == BEAT_LAST)
					state_next = blc_pkg::ST_REPLAY;
			blc_pkg::ST_REPLAY:
				state_next = blc_pkg::ST_IDLE;
		endcase
	end

	// Engine beats toward the shared port; scratch refills never use it
	assign eng_busy[b] = state_reg == blc_pkg::ST_WB || (state_reg == blc_pkg::ST_FILL && !pend_scr);
	assign eng[b] = {(state_reg == blc_pkg::ST_WB && !issued_reg && !lim_go) ||
		(state_reg == blc_pkg::ST_FILL && !issued_reg && !have_reg && !pend_scr),
		state_reg == blc_pkg::ST_WB,
		state_reg == blc_pkg::ST_WB ? vic_meta_reg.tag : pend_reg.addr[AW-1 -: TW],
		pend_set, BW'(b), beat_reg, 4'h0, d_rdata};
	assign ld[b] = owned_reg && owner_reg == BW'(b) && !out_reg.valid && !rd_wait_reg && eng[b].valid;
	assign dn[b] = owner_reg == BW'(b) && (wr_done || rd_done);

	// Control and answer registers
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= blc_pkg::ST_IDLE;
			ready_reg <= 1'b0;
			lim_ready_reg <= 1'b0;
			rsp_reg <= '0;
			probe_reg <= '0;
			ecc_reg <= 1'b0;
			cnt_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			ready_reg <= state_next == blc_pkg::ST_IDLE;
			lim_ready_reg <= state_next != blc_pkg::ST_REPLAY;
			rsp_reg <= rsp_next;
			probe_reg <= probe_next;
			ecc_reg <= ecc_hit;
			if (ecc_hit && cnt_reg != '1)
				cnt_reg <= cnt_reg + 1'b1;
		end
	end

	// Miss bookkeeping and refill beat buffer
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			pend_reg <= '0;
			vic_way_reg <= '0;
			vic_meta_reg <= '0;
			rr_reg <= '0;
			beat_reg <= '0;
			issued_reg <= 1'b0;
			have_reg <= 1'b0;
			fbuf_reg <= '0;
		end
		else
		begin
			if (miss_take)
			begin
				pend_reg <= in_req[b];
				vic_way_reg <= vic_way;
				vic_meta_reg <= vmeta;
				rr_reg <= rr_reg + 1'b1;
			end
			if ((state_reg == blc_pkg::ST_WB && dn[b]) || fill_wr)
				beat_reg <= beat_reg + 1'b1;
			if (ld[b])
				issued_reg <= 1'b1;
			else if (dn[b])
				issued_reg <= 1'b0;
			if (state_reg == blc_pkg::ST_FILL && dn[b])
			begin
				have_reg <= 1'b1;
				fbuf_reg <= out_rdata;
			end
			else if (fill_wr)
				have_reg <= 1'b0;
		end
	end

	assign in_ready[b] = ready_reg;
	assign in_lim_ready[b] = lim_ready_reg;
	assign in_rsp[b] = rsp_reg;
	assign probe[b] = probe_reg;
	assign ecc_event[b] = ecc_reg;
	assign ecc_count[b] = cnt_reg;
end

endmodule

// ===== tb/blc_l2_chk.sv
// Checker of the cache top: enables, window timing, outer port.
// Assumes blc_l2 with default geometry; bound below.
`timescale 1ns/10ps
`include "blc_map.svh"

module blc_l2_chk #(
	parameter int NBANK = `BLC_NBANK,
	parameter int NSET = `BLC_NSET,
	parameter int NWAY = `BLC_NWAY
)(
	input wire logic clock,
	input wire logic rst,
	input wire blc_pkg::blc_req_t [NBANK-1:0] in_req,
	input wire logic [NBANK-1:0] in_ready,
	input wire logic [NBANK-1:0] in_lim_ready,
	input wire blc_pkg::blc_rsp_t [NBANK-1:0] in_rsp,
	input wire blc_pkg::blc_out_t out_req,
	input wire logic out_ready,
	input wire logic way_enable_wr,
	input wire logic [NWAY-1:0] way_enable_data,
	input wire logic [NWAY-1:0] way_enabled,
	input wire logic [NBANK-1:0][`BLC_CNT_W-1:0] ecc_count
);
	localparam logic [`BLC_ADDR_W-1:0] LIM = `BLC_LIM_BASE;
	localparam logic [`BLC_ADDR_W-1:0] SCR = `BLC_SCR_BASE;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// ----------------------------------------
	// Way enables
	// ----------------------------------------
	way0_kept_a: assert property (way_enabled[0])
		else $error("way 0 not enabled");
	enable_sticky_a: assert property ((way_enabled & $past(way_enabled)) == $past(way_enabled))
		else $error("enabled way dropped");
	enable_set_a: assert property (way_enable_wr |=>
		way_enabled == ($past(way_enabled) | $past(way_enable_data)))
		else $error("enable write not merged");
	enable_idle_a: assert property (!way_enable_wr |=> $stable(way_enabled))
		else $error("enables changed without write");

	// ----------------------------------------
	// Inner ports
	// ----------------------------------------
	// Window requests are taken on either ready
	wire logic [NBANK-1:0] lim_take;
	for (genvar b = 0; b < NBANK; b++)
	begin : g_bank
		assign lim_take[b] = in_req[b].valid && (in_ready[b] || in_lim_ready[b])
			&& in_req[b].addr[37:21] == LIM[37:21];
		lim_answer_a: assert property (lim_take[b] |=>
			in_rsp[b].valid && in_rsp[b].id == $past(in_req[b].id))
			else $error("window answer late");
		lim_priority_a: assert property (!in_lim_ready[b] |=> in_lim_ready[b])
			else $error("window blocked two cycles");
		bank_check_a: assert property (in_req[b].valid && in_ready[b]
			&& in_req[b].addr[7:6] != 2'(b) |=> in_rsp[b].valid && in_rsp[b].err)
			else $error("wrong bank not refused");
	end

	// ----------------------------------------
	// Outer port and check counters
	// ----------------------------------------
	outer_hold_a: assert property (out_req.valid && !out_ready |=> out_req.valid
		&& $stable(out_req.addr) && $stable(out_req.write) && $stable(out_req.wdata))
		else $error("outer beat changed while stalled");
	scratch_nowb_a: assert property (out_req.valid && out_req.write |->
		out_req.addr[37:25] != SCR[37:25])
		else $error("scratch line written back");
	ecc_grow_a: assert property (ecc_count[0] >= $past(ecc_count[0]))
		else $error("error count fell");

	cover property (out_req.valid && out_ready && !out_req.write);
	cover property (|lim_take);
	cover property (way_enable_wr);
	cover property (in_rsp[0].valid && in_rsp[0].err);
endmodule

bind blc_l2 blc_l2_chk #(.NBANK(NBANK), .NSET(NSET), .NWAY(NWAY)) chk (
	.clock(clock),
	.rst(rst),
	.in_req(in_req),
	.in_ready(in_ready),
	.in_lim_ready(in_lim_ready),
	.in_rsp(in_rsp),
	.out_req(out_req),
	.out_ready(out_ready),
	.way_enable_wr(way_enable_wr),
	.way_enable_data(way_enable_data),
	.way_enabled(way_enabled),
	.ecc_count(ecc_count)
);

// ===== tb/blc_mem_model.sv
// Memory controller model on the outer port.
// Assumes one beat in flight; stalls and read delays follow a fixed pattern.
`timescale 1ns/10ps
`include "blc_map.svh"

module blc_mem_model (
	input wire logic clock,
	input wire logic rst,
	input wire blc_pkg::blc_out_t out_req,
	output logic out_ready,
	output logic out_rvalid,
	output logic [`BLC_DATA_W-1:0] out_rdata,
	output int n_reads,
	output int n_writes
);
	logic [`BLC_DATA_W-1:0] mem [logic [`BLC_ADDR_W-1:0]];
	logic [`BLC_ADDR_W-1:0] pend_addr;
	logic pend = 1'b0;
	int dly = 0, cyc = 0;

	initial
	begin
		out_ready = 1'b0;
		out_rvalid = 1'b0;
		out_rdata = '0;
		n_reads = 0;
		n_writes = 0;
	end

	// Beat taken when valid and ready are high
	always @(posedge clock)
	begin
		if (!rst && out_req.valid && out_ready)
		begin
			if (out_req.write)
			begin
				mem[out_req.addr] = out_req.wdata;
				n_writes++;
			end
			else
			begin
				pend = 1'b1;
				pend_addr = out_req.addr;
				dly = cyc % 4;
				n_reads++;
			end
		end
	end

	// Ready stalls one cycle in three; idle data toggles
	always @(negedge clock)
	begin
		cyc++;
		out_ready <= (cyc % 3) != 0;
		if (pend && dly == 0)
		begin
			out_rvalid <= 1'b1;
			out_rdata <= mem.exists(pend_addr) ? mem[pend_addr] : {4{pend_addr[31:0] ^ 32'hc3c3_0000}};
			pend = 1'b0;
		end
		else
		begin
			out_rvalid <= 1'b0;
			out_rdata <= ~out_rdata;
			if (pend)
				dly--;
		end
	end
endmodule

// ===== tb/blc_l2_test.sv
// Bench of the level-2 cache: window, enables, misses, scratch, check bits.
// Assumes the memory model on the outer port and default geometry.
`timescale 1ns/10ps
`include "blc_map.svh"

module blc_l2_test;
	localparam logic [37:0] LIM = `BLC_LIM_BASE;
	logic clock = 1'b0;
	logic rst;
	blc_pkg::blc_req_t [3:0] in_req;
	logic [3:0] in_ready, in_lim_ready;
	blc_pkg::blc_rsp_t [3:0] in_rsp;
	blc_pkg::blc_out_t out_req;
	logic out_ready, out_rvalid;
	logic [127:0] out_rdata;
	logic way_enable_wr;
	logic [15:0] way_enable_data, way_mask, way_lock, way_enabled;
	logic ecc_inject;
	logic [3:0][15:0] ecc_count;
	int num_errors = 0;
	int n_compared = 0;
	int n_reads, n_writes, r0, w0;
	logic [31:0] rng = 32'h9bc1_c130;
	logic [37:0] la [16];
	logic [127:0] ld [16], d;

	always #2 clock = ~clock;

	blc_l2 DUT (.clock(clock), .rst(rst), .in_req(in_req), .in_ready(in_ready),
		.in_lim_ready(in_lim_ready), .in_rsp(in_rsp), .probe(), .out_req(out_req),
		.out_ready(out_ready), .out_rvalid(out_rvalid), .out_rdata(out_rdata),
		.way_enable_wr(way_enable_wr), .way_enable_data(way_enable_data),
		.way_mask(way_mask), .way_lock(way_lock), .ecc_inject(ecc_inject),
		.way_enabled(way_enabled), .ecc_event(), .ecc_count(ecc_count));

	blc_mem_model mem (.clock(clock), .rst(rst), .out_req(out_req), .out_ready(out_ready),
		.out_rvalid(out_rvalid), .out_rdata(out_rdata), .n_reads(n_reads),
		.n_writes(n_writes));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	// Window slot s, set st, bank b, beat 0
	function automatic logic [37:0] waddr(input int s, input int st, input int b);
		return LIM | (38'(s) << 17) | (38'(st & 511) << 8) | (38'(b) << 6);
	endfunction

	task automatic results();
		if (num_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
		n_compared++;
		if (got !== exp)
		begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask

	// One request on port b; reads compare with d; fast wants hit latency
	task automatic op(input int b, input logic wr, input logic [37:0] a, input logic [127:0] d,
		input logic e, input logic fast);
		int k, lat;
		logic [31:0] t;
		logic win;
		t = xs();
		win = a[37:21] == LIM[37:21];
		in_req[b] = '{1'b1, wr, 2'(b), t[3:0], a, d, 16'hffff};
		k = 0;
		while (!(in_ready[b] || (in_lim_ready[b] && win)) && k < 300)
		begin
			@(negedge clock);
			k++;
		end
		@(negedge clock);
		in_req[b].valid = 1'b0;
		lat = 0;
		while (in_rsp[b].valid !== 1'b1 && lat < 300)
		begin
			@(negedge clock);
			lat++;
		end
		if (k >= 300 || lat >= 300)
		begin
			$display("unexpected wait on bank %0d", b);
			num_errors++;
			results();
		end
		check("rsp_err", 128'(e), 128'(in_rsp[b].err));
		check("rsp_id", 128'(t[3:0]), 128'(in_rsp[b].id));
		if (fast)
			check("latency", 128'(0), 128'(lat));
		if (!wr && !e)
			check("rdata", d, in_rsp[b].rdata);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		rst = 1'b1;
		in_req = '0;
		way_enable_wr = 1'b0;
		way_enable_data = '0;
		way_mask = '0;
		way_lock = '0;
		ecc_inject = 1'b0;
		repeat (2) @(negedge clock);
		rst = 1'b0;
		@(negedge clock);
		check("way_enabled", 128'h0001, 128'(way_enabled));
		check("ecc_count", 128'h0, 128'(ecc_count));
		// Every window slot, slot 15 being the caching way 0
		for (int s = 0; s < 16; s++)
		begin
			la[s] = waddr(s, xs(), s % 4);
			ld[s] = {xs(), xs(), xs(), xs()};
			op(s % 4, 1'b1, la[s], ld[s], s == 15, 1'b1);
		end
		for (int s = 0; s < 15; s++)
			op(s % 4, 1'b0, la[s], ld[s], 1'b0, 1'b1);
		// All four banks answer in the same cycle
		for (int b = 0; b < 4; b++)
			in_req[b] = '{1'b1, 1'b0, 2'(b), 4'(b), la[4 + b], 128'h0, 16'hffff};
		@(negedge clock);
		for (int b = 0; b < 4; b++)
			in_req[b].valid = 1'b0;
		for (int b = 0; b < 4; b++)
			check("parallel", {1'b1, ld[4 + b]}, {in_rsp[b].valid, in_rsp[b].rdata});
		// Way 14 leaves slot 1; a later zero write changes nothing
		for (int k = 0; k < 2; k++)
		begin
			way_enable_wr = 1'b1;
			way_enable_data = k == 0 ? 16'h4000 : 16'h0000;
			@(negedge clock);
			way_enable_wr = 1'b0;
			@(negedge clock);
			check("way_enabled", 128'h4001, 128'(way_enabled));
		end
		op(1, 1'b0, la[1], ld[1], 1'b1, 1'b1);
		op(0, 1'b0, la[0], ld[0], 1'b0, 1'b1);
		op(2, 1'b0, la[5], ld[5], 1'b1, 1'b1);
		// Cached miss refills four beats, then hits
		r0 = n_reads;
		op(1, 1'b0, 38'h0_1000_0040, {4{32'h1000_0040 ^ 32'hc3c3_0000}}, 1'b0, 1'b0);
		check("refill_beats", 128'(r0 + 4), 128'(n_reads));
		op(1, 1'b0, 38'h0_1000_0070, {4{32'h1000_0070 ^ 32'hc3c3_0000}}, 1'b0, 1'b1);
		d = {xs(), xs(), xs(), xs()};
		op(1, 1'b1, 38'h0_1000_0050, d, 1'b0, 1'b1);
		op(1, 1'b0, 38'h0_1000_0050, d, 1'b0, 1'b1);
		// Three scratch lines in one set evict with no memory traffic
		r0 = n_reads;
		w0 = n_writes;
		for (int k = 0; k < 3; k++)
			op(2, 1'b1, 38'h0_0A00_0080 + (38'(k) << 17), ld[k], 1'b0, 1'b0);
		op(2, 1'b0, 38'h0_0A04_0080, ld[2], 1'b0, 1'b1);
		op(2, 1'b0, 38'h0_0A04_0090, 128'h0, 1'b0, 1'b1);
		check("outer_traffic", 128'({r0, w0}), 128'({n_reads, n_writes}));
		// Masked or locked ways leave no room for a scratch line
		for (int k = 0; k < 2; k++)
		begin
			way_mask = k == 0 ? 16'h4001 : 16'h0000;
			way_lock = k == 1 ? 16'h4001 : 16'h0000;
			op(2, 1'b1, 38'h0_0A00_0280, ld[3], 1'b1, 1'b0);
		end
		way_lock = '0;
		// Injected check error is reported and counted
		ecc_inject = 1'b1;
		op(0, 1'b1, la[4], ld[4], 1'b0, 1'b1);
		ecc_inject = 1'b0;
		op(0, 1'b0, la[4], ld[4], 1'b1, 1'b1);
		repeat (2) @(negedge clock);
		check("ecc_count", 128'h0001, 128'(ecc_count[0]));
		results();
	end
endmodule
